// ===== core/plma_core.sv
// plma_core: eight-macrocell programmable logic array with axi4-lite config
// assumes pins are asynchronous to clk; a programmer loads config over axi
//
// Contract
// - power-up clears every macrocell register low
// - registered outputs read high after power-up
// - preload forces each register high or low
// - security fuse blocks verify and preload
// - 64-bit signature always readable
// - macrocell is one of four types
// - one of three architecture modes
// - undriven inputs read high via pull-up
// - registered cells use shared clock and oe
// - complex: seven sum terms, one oe term
// - simple: eight sum terms, always enabled
// - dedicated input keeps driver disabled
`timescale 1ns/1ps
module plma_core (
   input wire logic clk,
   input wire logic rst_n,
   input wire plma_pkg::plma_axi_req_type axi_req,
   output plma_pkg::plma_axi_rsp_type axi_rsp,
   input wire logic clk_pin,
   input wire logic oe_n_pin,
   input wire logic [7:0] in_pin,
   input wire logic [7:0] in_pin_drv,
   input wire logic [7:0] io_in,
   input wire logic [7:0] io_in_drv,
   output logic [7:0] io_out,
   output logic [7:0] io_oe_n
);
   import plma_pkg::*;

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) r[8*b +: 8] = nw[8*b +: 8];
      end
      return r;
   endfunction

   function automatic plma_mc_type mc_of(input logic [31:0] cfg, input int i);
      return plma_mc_type'(cfg[4*i +: 4]);
   endfunction

   function automatic logic cfg_legal(input logic [31:0] cfg);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < NUM_MC; i++) begin
         if (!$onehot(cfg[4*i +: 4])) ok = 1'b0;
      end
      return ok;
   endfunction

   // pin synchronisers
   logic [SYNC_W-1:0] sync1_q;
   logic [SYNC_W-1:0] sync2_q;
   logic clk_pin3_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1_q <= '0;
         sync2_q <= '0;
         clk_pin3_q <= 1'b0;
      end else begin
         sync1_q <= {clk_pin, oe_n_pin, in_pin, in_pin_drv, io_in, io_in_drv};
         sync2_q <= sync1_q;
         clk_pin3_q <= sync2_q[SYNC_W-1];
      end
   end
   logic clk_rise;
   logic oe_pin_act;
   logic [7:0] in_lvl;
   logic [7:0] io_lvl;
   assign clk_rise = sync2_q[SYNC_W-1] & ~clk_pin3_q;
   assign oe_pin_act = ~sync2_q[SYNC_W-2];
   assign in_lvl = sync2_q[31:24] | ~sync2_q[23:16];
   assign io_lvl = sync2_q[15:8] | ~sync2_q[7:0];

   // power-up reset interval
   plma_state_type st_q;
   logic [PWR_CNT_W-1:0] pwr_cnt_q;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= PLMA_ST_PWRUP;
         pwr_cnt_q <= '0;
      end else if (st_q == PLMA_ST_PWRUP) begin
         pwr_cnt_q <= pwr_cnt_q + 1'b1;
         if (pwr_cnt_q == PWR_CNT_W'(TPR_CYC - 1)) st_q <= PLMA_ST_READY;
      end
   end

   // bus channels
   logic awready_q, aw_have_q, wready_q, w_have_q, bvalid_q, arready_q, rvalid_q;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic [1:0] bresp_q, rresp_q;
   logic [31:0] rdata_q;
   logic wr_fire, rd_fire;
   assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
   assign rd_fire = axi_req.arvalid & arready_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         awready_q <= 1'b0;
         aw_have_q <= 1'b0;
         aw_addr_q <= '0;
      end else if (awready_q && axi_req.awvalid) begin
         aw_have_q <= 1'b1;
         aw_addr_q <= axi_req.awaddr;
         awready_q <= 1'b0;
      end else if (wr_fire) begin
         aw_have_q <= 1'b0;
      end else begin
         awready_q <= ~aw_have_q & ~bvalid_q;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wready_q <= 1'b0;
         w_have_q <= 1'b0;
         w_data_q <= '0;
         w_strb_q <= '0;
      end else if (wready_q && axi_req.wvalid) begin
         w_have_q <= 1'b1;
         w_data_q <= axi_req.wdata;
         w_strb_q <= axi_req.wstrb;
         wready_q <= 1'b0;
      end else if (wr_fire) begin
         w_have_q <= 1'b0;
      end else begin
         wready_q <= ~w_have_q & ~bvalid_q;
      end
   end

   // configuration and state
   plma_mode_type mode_q;
   logic run_q, fuse_q, refused_q;
   logic [7:0] pol_q;
   logic [31:0] mcfg_q;
   logic [63:0] sig_q;
   logic [NUM_MC-1:0] mc_q;
   logic [NUM_MC-1:0][NUM_PT-1:0][LIT_W-1:0] term_q;
   logic [31:0] wd;
   logic is_term_w, pre_ok;
   logic [7:0] pre_sel, pre_val;
   assign is_term_w = aw_addr_q[11:8] == TERM_PAGE;
   assign pre_ok = wr_fire & (aw_addr_q == OFS_PRELOAD) & ~fuse_q & (st_q == PLMA_ST_READY);
   assign pre_sel = w_data_q[PRE_SEL_LSB +: 8] & {8{w_strb_q[1]}};
   assign pre_val = w_data_q[PRE_VAL_LSB +: 8];

   always_comb begin
      wd = '0;
      unique case (aw_addr_q)
         OFS_CTRL: wd = {16'h0000, pol_q, 3'h0, 1'b0, mode_q, run_q};
         OFS_MCFG: wd = mcfg_q;
         OFS_SIG_LO: wd = sig_q[31:0];
         OFS_SIG_HI: wd = sig_q[63:32];
         default: wd = term_q[aw_addr_q[7:5]][aw_addr_q[4:2]];
      endcase
      wd = merge(wd, w_data_q, w_strb_q);
   end

   logic wr_ok;
   always_comb begin
      wr_ok = 1'b0;
      if (is_term_w) wr_ok = ~run_q & ~fuse_q;
      else begin
         unique case (aw_addr_q)
            OFS_CTRL: wr_ok = run_q | ($onehot(wd[CTRL_MODE_LSB +: 3]) &
                                      (|wd[CTRL_MODE_LSB +: 3]));
            OFS_MCFG: wr_ok = ~run_q & cfg_legal(wd);
            OFS_FUSE: wr_ok = 1'b1;
            OFS_PRELOAD: wr_ok = ~fuse_q & (st_q == PLMA_ST_READY);
            OFS_STATUS: wr_ok = 1'b1;
            OFS_SIG_LO, OFS_SIG_HI: wr_ok = ~run_q;
            default: wr_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         mode_q <= PLMA_MODE_REG;
         pol_q <= POL_RST;
         mcfg_q <= MCFG_RST;
         sig_q <= SIG_RST;
         fuse_q <= 1'b0;
         term_q <= '0;
      end else if (wr_fire && wr_ok) begin
         if (is_term_w) term_q[aw_addr_q[7:5]][aw_addr_q[4:2]] <= wd;
         unique case (aw_addr_q)
            OFS_CTRL: begin
               run_q <= wd[CTRL_RUN_BIT];
               if (!run_q) begin
                  mode_q <= plma_mode_type'(wd[CTRL_MODE_LSB +: 3]);
                  pol_q <= wd[CTRL_POL_LSB +: 8];
                  if (wd[CTRL_ERASE_BIT]) begin
                     term_q <= '0;
                     fuse_q <= 1'b0;
                  end
               end
            end
            OFS_MCFG: mcfg_q <= wd;
            OFS_FUSE: if (wd[FUSE_BIT]) fuse_q <= 1'b1;
            OFS_SIG_LO: sig_q[31:0] <= wd;
            OFS_SIG_HI: sig_q[63:32] <= wd;
            default: run_q <= run_q;
         endcase
      end
   end

   // macrocell array
   logic [LIT_W-1:0] lits;
   logic [NUM_SIG-1:0] sigs;
   logic [NUM_MC-1:0] sum_d, pin_val, pin_en, fb, reg_mask, in_mask;
   always_comb begin
      for (int i = 0; i < NUM_MC; i++) begin
         reg_mask[i] = (mode_q == PLMA_MODE_REG) && (mc_of(mcfg_q, i) == PLMA_MC_REG);
         in_mask[i] = mc_of(mcfg_q, i) == PLMA_MC_IN;
         if (reg_mask[i]) fb[i] = mc_q[i];
         else if (mc_of(mcfg_q, i) == PLMA_MC_COUT) fb[i] = io_out[i];
         else fb[i] = io_lvl[i];
      end
      sigs = {fb, in_lvl};
      for (int k = 0; k < NUM_SIG; k++) begin
         lits[2*k] = sigs[k];
         lits[2*k+1] = ~sigs[k];
      end
   end

   for (genvar g = 0; g < NUM_MC; g++) begin : g_mc
      plma_macrocell u_mc (
         .lits(lits),
         .terms(term_q[g]),
         .mode(mode_q),
         .mc_type(mc_of(mcfg_q, g)),
         .pol(pol_q[g]),
         .reg_q(mc_q[g]),
         .oe_pin_act(oe_pin_act),
         .sum_d(sum_d[g]),
         .pin_val(pin_val[g]),
         .pin_en(pin_en[g])
      );
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mc_q <= '0;
      else if (st_q == PLMA_ST_PWRUP) mc_q <= '0;
      else if (pre_ok) mc_q <= (mc_q & ~pre_sel) | (pre_val & pre_sel);
      else if (clk_rise && run_q) mc_q <= (mc_q & ~reg_mask) | (sum_d & reg_mask);
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         io_out <= 8'hff;
         io_oe_n <= 8'hff;
      end else if (st_q == PLMA_ST_PWRUP || !run_q) begin
         io_out <= ~mc_q;
         io_oe_n <= 8'hff;
      end else begin
         io_out <= pin_val;
         io_oe_n <= ~(pin_en & ~in_mask);
      end
   end

   // refused-request flag, set wins over clear
   logic refuse_ev;
   assign refuse_ev = (wr_fire & fuse_q & ((aw_addr_q == OFS_PRELOAD) | is_term_w)) |
                      (rd_fire & fuse_q & (axi_req.araddr[11:8] == TERM_PAGE));
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) refused_q <= 1'b0;
      else if (refuse_ev) refused_q <= 1'b1;
      else if (wr_fire && aw_addr_q == OFS_STATUS && wd[STAT_REFUSED_BIT]) refused_q <= 1'b0;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_fire) begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (axi_req.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (rd_fire) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         rdata_q <= '0;
         if (axi_req.araddr[11:8] == TERM_PAGE) begin
            if (fuse_q) rresp_q <= RESP_SLVERR;
            else rdata_q <= term_q[axi_req.araddr[7:5]][axi_req.araddr[4:2]];
         end else begin
            unique case (axi_req.araddr)
               OFS_CTRL: rdata_q <= {16'h0000, pol_q, 3'h0, 1'b0, mode_q, run_q};
               OFS_MCFG: rdata_q <= mcfg_q;
               OFS_FUSE: rdata_q <= {31'h0, fuse_q};
               OFS_PRELOAD: rdata_q <= '0;
               OFS_STATUS: rdata_q <= {13'h0, refused_q, st_q == PLMA_ST_PWRUP, fuse_q,
                                       io_out, mc_q};
               OFS_SIG_LO: rdata_q <= sig_q[31:0];
               OFS_SIG_HI: rdata_q <= sig_q[63:32];
               default: rresp_q <= RESP_SLVERR;
            endcase
         end
      end else if (rvalid_q) begin
         if (axi_req.rready) rvalid_q <= 1'b0;
      end else begin
         arready_q <= 1'b1;
      end
   end

   assign axi_rsp = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q, bresp: bresp_q,
                      arready: arready_q, rvalid: rvalid_q, rdata: rdata_q, rresp: rresp_q};

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_pwr_last;
      st_q == PLMA_ST_PWRUP && pwr_cnt_q == PWR_CNT_W'(TPR_CYC - 1);
   endsequence
   a_pwrup_clear: assert property (st_q == PLMA_ST_PWRUP |=> mc_q == '0)
      else $error("register not clear during power-up");
   a_pwrup_ends: assert property (s_pwr_last |=> st_q == PLMA_ST_READY ##1 mc_q == '0)
      else $error("power-up interval length wrong");
   a_reg_out_high: assert property ((st_q == PLMA_ST_PWRUP)[*2] |-> io_out == 8'hff)
      else $error("registered outputs not high after power-up");
   a_preload_force: assert property (pre_ok |=> mc_q == (($past(mc_q) & ~$past(pre_sel)) |
      ($past(pre_val) & $past(pre_sel))))
      else $error("preload value not applied");
   a_secure_preload: assert property (wr_fire && fuse_q && aw_addr_q == OFS_PRELOAD |=>
      bresp_q == RESP_SLVERR && bvalid_q)
      else $error("preload accepted while secured");
   a_secure_verify: assert property (rd_fire && fuse_q && axi_req.araddr[11:8] == TERM_PAGE
      |=> rresp_q == RESP_SLVERR && rdata_q == '0)
      else $error("term readback while secured");
   a_sig_read: assert property (rd_fire && axi_req.araddr == OFS_SIG_HI |=>
      rdata_q == $past(sig_q[63:32]) && rresp_q == RESP_OKAY)
      else $error("signature not readable");
   a_input_off: assert property (1'b1 |=> ($past(in_mask) & ~io_oe_n) == '0)
      else $error("dedicated input driven");
   a_reg_load: assert property (clk_rise && run_q && !pre_ok && st_q == PLMA_ST_READY |=>
      ((mc_q ^ $past(sum_d)) & $past(reg_mask)) == '0)
      else $error("register missed clock edge");
   a_simple_on: assert property (run_q && st_q == PLMA_ST_READY && mode_q == PLMA_MODE_SIMP
      |=> (~$past(in_mask) & io_oe_n) == '0)
      else $error("simple output not enabled");
   a_cfg_static: assert property (run_q && $stable(run_q) |=>
      $stable(mode_q) && $stable(mcfg_q))
      else $error("configuration changed while running");
endmodule // plma_core

// ===== core/plma_pkg.sv
// plma_pkg: constants, register map and types of the macrocell array
// assumes a single 125 MHz clock and an axi4-lite master with 32-bit data
package plma_pkg;
   localparam int ADDR_W = 12;
   localparam int NUM_MC = 8;
   localparam int NUM_PT = 8;
   localparam int NUM_SIG = 16;
   localparam int LIT_W = 32;
   localparam int SYNC_W = 34;

   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_MCFG = 12'h004;
   localparam logic [11:0] OFS_FUSE = 12'h008;
   localparam logic [11:0] OFS_PRELOAD = 12'h00c;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_SIG_LO = 12'h014;
   localparam logic [11:0] OFS_SIG_HI = 12'h018;
   localparam logic [3:0] TERM_PAGE = 4'h1;

   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_MODE_LSB = 1;
   localparam int CTRL_ERASE_BIT = 4;
   localparam int CTRL_POL_LSB = 8;
   localparam int PRE_VAL_LSB = 0;
   localparam int PRE_SEL_LSB = 8;
   localparam int STAT_REG_LSB = 0;
   localparam int STAT_PIN_LSB = 8;
   localparam int STAT_FUSE_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;
   localparam int STAT_REFUSED_BIT = 18;
   localparam int FUSE_BIT = 0;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   localparam logic [31:0] MCFG_RST = 32'h8888_8888;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [63:0] SIG_RST = 64'h0000_0000_0000_0000;

   localparam int CLK_PERIOD_NS = 8;
   localparam int TPR_MAX_NS = 1000;
   localparam int TPR_CYC = TPR_MAX_NS / CLK_PERIOD_NS;
   localparam int PWR_CNT_W = 8;

   typedef enum logic [2:0] {
      PLMA_MODE_REG = 3'h1,
      PLMA_MODE_CPLX = 3'h2,
      PLMA_MODE_SIMP = 3'h4
   } plma_mode_type;

   typedef enum logic [3:0] {
      PLMA_MC_REG = 4'h1,
      PLMA_MC_CIO = 4'h2,
      PLMA_MC_COUT = 4'h4,
      PLMA_MC_IN = 4'h8
   } plma_mc_type;

   typedef enum logic [1:0] {
      PLMA_ST_PWRUP = 2'h1,
      PLMA_ST_READY = 2'h2
   } plma_state_type;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } plma_axi_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } plma_axi_rsp_type;
endpackage

// ===== core/plma_macrocell.sv
// plma_macrocell: product terms, sum term and pin drive of one macrocell
// assumes static configuration inputs and a registered state from the caller
`timescale 1ns/1ps
module plma_macrocell (
   input wire logic [plma_pkg::LIT_W-1:0] lits,
   input wire logic [plma_pkg::NUM_PT-1:0][plma_pkg::LIT_W-1:0] terms,
   input wire plma_pkg::plma_mode_type mode,
   input wire plma_pkg::plma_mc_type mc_type,
   input wire logic pol,
   input wire logic reg_q,
   input wire logic oe_pin_act,
   output logic sum_d,
   output logic pin_val,
   output logic pin_en
);
   import plma_pkg::*;
   logic [NUM_PT-1:0] pt;
   logic sum8;
   logic sum7;

   always_comb begin
      for (int p = 0; p < NUM_PT; p++) begin
         pt[p] = &(~terms[p] | lits);
      end
      sum8 = |pt;
      sum7 = |pt[NUM_PT-1:1];
      sum_d = sum8 ^ pol;
      pin_val = 1'b1;
      pin_en = 1'b0;
      unique case (mode)
         PLMA_MODE_REG: begin
            if (mc_type == PLMA_MC_REG) begin
               pin_val = ~reg_q;
               pin_en = oe_pin_act;
            end else if (mc_type != PLMA_MC_IN) begin
               pin_val = sum7 ^ pol;
               pin_en = pt[0];
            end
         end
         PLMA_MODE_CPLX: begin
            if (mc_type != PLMA_MC_IN) begin
               pin_val = sum7 ^ pol;
               pin_en = pt[0];
            end
         end
         PLMA_MODE_SIMP: begin
            if (mc_type != PLMA_MC_IN) begin
               pin_val = sum8 ^ pol;
               pin_en = 1'b1;
            end
         end
         default: begin
            pin_en = 1'b0;
         end
      endcase
   end
endmodule // plma_macrocell

// ===== sim/plma_sys_model.sv
// plma_sys_model: system logic that drives the array pins of plma_core
// assumes clk is the bench clock; the bench calls set_pins and pulse
`timescale 1ns/1ps
module plma_sys_model (
   input wire logic clk,
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe_n,
   output logic clk_pin,
   output logic oe_n_pin,
   output logic [7:0] in_pin,
   output logic [7:0] in_pin_drv,
   output logic [7:0] io_in,
   output logic [7:0] io_in_drv
);
   logic [7:0] val_q;
   initial begin
      clk_pin = 1'b0;
      oe_n_pin = 1'b1;
      val_q = 8'h00;
      in_pin_drv = 8'h00;
   end
   // undriven bits show the inverse value; the device supplies the pull-up
   assign in_pin = val_q ^ ~in_pin_drv;
   assign io_in = (io_out & ~io_oe_n) | (~val_q & io_oe_n);
   assign io_in_drv = ~io_oe_n;
   task automatic set_pins(input logic [7:0] v, input logic [7:0] d, input logic oe_n);
      @(posedge clk);
      val_q <= v;
      in_pin_drv <= d;
      oe_n_pin <= oe_n;
   endtask
   // inputs settle for several cycles before the rising edge
   task automatic pulse();
      repeat (6) @(posedge clk);
      clk_pin <= 1'b1;
      repeat (4) @(posedge clk);
      clk_pin <= 1'b0;
   endtask
endmodule // plma_sys_model

// ===== sim/testbench.sv
// testbench: self-checking bench for plma_core over axi4-lite and pins
// assumes plma_pkg and plma_sys_model are compiled first
`timescale 1ns/1ps
module testbench;
   import plma_pkg::*;
   typedef struct packed {
      logic [31:0] d;
      logic [31:0] m;
      logic [1:0] r;
   } plma_exp_type;
   logic clk;
   logic rst_n;
   plma_axi_req_type axi_req;
   plma_axi_rsp_type axi_rsp;
   logic clk_pin, oe_n_pin;
   logic [7:0] in_pin, in_pin_drv, io_in, io_in_drv, io_out, io_oe_n;
   plma_exp_type bq[$];
   plma_exp_type rq[$];
   plma_exp_type ex;
   int num_errors = 0;
   int cmp_count = 0;
   logic [7:0] lfsr_q = 8'h58;
   logic [7:0] eff;
   logic reg_exp;

   plma_core dut_u (.clk(clk), .rst_n(rst_n), .axi_req(axi_req), .axi_rsp(axi_rsp),
      .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .in_pin(in_pin), .in_pin_drv(in_pin_drv),
      .io_in(io_in), .io_in_drv(io_in_drv), .io_out(io_out), .io_oe_n(io_oe_n));
   plma_sys_model sys_u (.clk(clk), .io_out(io_out), .io_oe_n(io_oe_n), .clk_pin(clk_pin),
      .oe_n_pin(oe_n_pin), .in_pin(in_pin), .in_pin_drv(in_pin_drv), .io_in(io_in),
      .io_in_drv(io_in_drv));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   // cell0 toggles on feedback, cell1 inverts in1, cell2 enabled by in2
   function automatic logic [31:0] tval(input int c, input int t);
      if (t == 0) return (c == 0) ? 32'h0002_0000 : ((c == 1) ? 32'h0 : 32'h10);
      if (t == 1 && c > 0) return (c == 1) ? 32'h8 : 32'h0;
      return 32'h3;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
      bq.push_back('{32'h0, 32'h0, r});
      @(posedge clk);
      axi_req.awaddr <= a;
      axi_req.wdata <= d;
      axi_req.wstrb <= 4'hf;
      axi_req.awvalid <= 1'b1;
      axi_req.wvalid <= 1'b1;
      axi_req.bready <= 1'b1;
      do begin
         @(posedge clk);
         if (axi_rsp.awready) axi_req.awvalid <= 1'b0;
         if (axi_rsp.wready) axi_req.wvalid <= 1'b0;
      end while (!axi_rsp.bvalid);
      axi_req.bready <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic [31:0] m,
                     input logic [1:0] r);
      rq.push_back('{d, m, r});
      @(posedge clk);
      axi_req.araddr <= a;
      axi_req.arvalid <= 1'b1;
      axi_req.rready <= 1'b1;
      do begin
         @(posedge clk);
         if (axi_rsp.arready) axi_req.arvalid <= 1'b0;
      end while (!axi_rsp.rvalid);
      axi_req.rready <= 1'b0;
   endtask

   // response monitor: oldest expectation against each answer
   always @(posedge clk) begin
      if (axi_rsp.bvalid && axi_req.bready) begin
         ex = bq.pop_front();
         chk({30'h0, axi_rsp.bresp}, {30'h0, ex.r});
      end
      if (axi_rsp.rvalid && axi_req.rready) begin
         ex = rq.pop_front();
         chk(axi_rsp.rdata & ex.m, ex.d);
         chk({30'h0, axi_rsp.rresp}, {30'h0, ex.r});
      end
   end

   initial begin
      #200000;
      num_errors++;
      $display("Error at %0t: timeout", $time);
      summarize();
   end

   initial begin
      rst_n = 1'b0;
      axi_req = '0;
      reg_exp = 1'b0;
      repeat (6) @(posedge clk);
      chk({16'h0, io_out, io_oe_n}, 32'hffff);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, 32'h0002_ff00, 32'h0002_ffff, RESP_OKAY);
      wr(OFS_PRELOAD, 32'h0000_0101, RESP_SLVERR);
      repeat (TPR_CYC) @(posedge clk);
      rd(OFS_STATUS, 32'h0000_ff00, 32'h0002_ffff, RESP_OKAY);
      chk({16'h0, io_out, io_oe_n}, 32'hffff);
      rd(OFS_CTRL, 32'h0, 32'h0000_ff01, RESP_OKAY);
      rd(OFS_MCFG, MCFG_RST, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_FUSE, 32'h0, 32'h1, RESP_OKAY);
      rd(OFS_SIG_LO, SIG_RST[31:0], 32'hffff_ffff, RESP_OKAY);
      rd(12'h01c, 32'h0, 32'h0, RESP_SLVERR);
      wr(12'h01c, 32'h1, RESP_SLVERR);
      wr(OFS_CTRL, 32'h6, RESP_SLVERR);
      wr(OFS_MCFG, 32'h8888_8423, RESP_SLVERR);
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wr(OFS_MCFG, 32'h8888_8421, RESP_OKAY);
      for (int c = 0; c < 3; c++) begin
         for (int t = 0; t < NUM_PT; t++) begin
            wr(12'h100 + 12'(4 * (8 * c + t)), tval(c, t), RESP_OKAY);
         end
      end
      rd(12'h100, 32'h0002_0000, 32'hffff_ffff, RESP_OKAY);
      wr(OFS_CTRL, 32'h3, RESP_OKAY);
      wr(OFS_MCFG, 32'h8888_8888, RESP_SLVERR);
      for (int k = 0; k < 8; k++) begin
         lfsr_q = lfsr(lfsr_q);
         sys_u.set_pins(lfsr_q, {lfsr_q[3:0], lfsr_q[7:4]}, lfsr_q[7]);
         sys_u.pulse();
         reg_exp = ~reg_exp;
         eff = lfsr_q | ~{lfsr_q[3:0], lfsr_q[7:4]};
         repeat (8) @(posedge clk);
         chk({16'h0, io_out & 8'h03, io_oe_n & 8'h0f},
             {22'h0, ~eff[1], ~reg_exp, 4'h0, 1'b1, ~eff[2], 1'b0, lfsr_q[7]});
         rd(OFS_STATUS, {31'h0, reg_exp}, 32'h1, RESP_OKAY);
      end
      for (int k = 0; k < 2; k++) begin
         wr(OFS_PRELOAD, {16'h0, 8'h01, 7'h0, ~reg_exp}, RESP_OKAY);
         reg_exp = ~reg_exp;
         repeat (8) @(posedge clk);
         chk({31'h0, io_out[0]}, {31'h0, ~reg_exp});
         rd(OFS_STATUS, {31'h0, reg_exp}, 32'h1, RESP_OKAY);
      end
      wr(OFS_CTRL, 32'h2, RESP_OKAY);
      wr(OFS_MCFG, 32'h8888_8448, RESP_OKAY);
      wr(OFS_CTRL, 32'h9, RESP_OKAY);
      sys_u.set_pins(8'h00, 8'hff, 1'b1);
      repeat (8) @(posedge clk);
      chk({16'h0, io_out & 8'h06, io_oe_n & 8'h0f}, 32'h0000_0609);
      wr(OFS_CTRL, 32'h8, RESP_OKAY);
      wr(OFS_CTRL, 32'h405, RESP_OKAY);
      repeat (8) @(posedge clk);
      chk({16'h0, io_out & 8'h06, io_oe_n & 8'h0f}, 32'h0000_020d);
      wr(OFS_CTRL, 32'h8, RESP_OKAY);
      wr(OFS_SIG_LO, 32'h1234_5678, RESP_OKAY);
      wr(OFS_SIG_HI, 32'h9abc_def0, RESP_OKAY);
      wr(OFS_FUSE, 32'h1, RESP_OKAY);
      wr(OFS_PRELOAD, 32'h0000_0101, RESP_SLVERR);
      rd(12'h104, 32'h0, 32'h0, RESP_SLVERR);
      rd(OFS_STATUS, 32'h0005_0000, 32'h0005_0000, RESP_OKAY);
      wr(OFS_STATUS, 32'h0004_0000, RESP_OKAY);
      rd(OFS_STATUS, 32'h0001_0000, 32'h0005_0000, RESP_OKAY);
      rd(OFS_SIG_LO, 32'h1234_5678, 32'hffff_ffff, RESP_OKAY);
      rd(OFS_SIG_HI, 32'h9abc_def0, 32'hffff_ffff, RESP_OKAY);
      wr(OFS_CTRL, 32'h12, RESP_OKAY);
      rd(OFS_FUSE, 32'h0, 32'h1, RESP_OKAY);
      rd(12'h100, 32'h0, 32'hffff_ffff, RESP_OKAY);
      repeat (4) @(posedge clk);
      summarize();
   end
endmodule // testbench
